// ### flat_panel_port_packer.sv
// Purpose: pack controller panel data onto the shared 12-line panel port
// Assumes: controller signals are asynchronous to clk; AHB-Lite registers
// Notes: TFT 9/12-bit and packed 8-bit colour STN mappings
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fpp_params.svh"
//////////////////////////////////////////////////////////////////////////
module flat_panel_port_packer #(
    parameter int DATA_W = `FPP_DATA_W,
    parameter int FIFO_DEPTH = `FPP_FIFO_DEPTH,
    parameter int HALF_CYCLES = `FPP_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [DATA_W-1:0] controller_panel_data,
    input wire logic controller_shift_clock,
    input wire logic controller_line_pulse,
    input wire logic controller_frame_marker,
    input wire logic controller_alt_drive,
    input wire logic controller_display_active,
    output logic [`FPP_LINES-1:0] panel_line,
    output logic panel_shift_clock,
    output logic lower_shift_clock,
    output logic line_latch_pulse,
    output logic first_line_marker,
    output logic alternating_drive,
    output logic crt_select,
    output logic capture_ready
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int BW = `FPP_BYTE_W;

    logic [`FPP_CTRL_W-1:0] ctrl_q;
    logic ovf_q;
    logic wr_pend_q;
    logic [`FPP_ADDR_W-1:0] wr_addr_q;
    logic addr_ok;
    logic [DATA_W-1:0] pd_s1;
    logic [DATA_W-1:0] pd_s2;
    logic [`FPP_SY_W-1:0] ctl_s1;
    logic [`FPP_SY_W-1:0] ctl_s2;
    logic sck_s3;
    logic lp_s3;
    logic cap;
    logic lp_rise;
    logic pair_q;
    logic [BW-1:0] even_q;
    logic push_valid;
    logic [DATA_W-1:0] push_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;
    logic [CW-1:0] fifo_count;
    logic ovf_event;
    fpp_pkg::out_state_t st_q;
    logic [7:0] div_q;
    logic last;
    logic [DATA_W-1:0] word_q;
    logic upper_shift_clock;
    logic panel_active;
    logic stn;
    fpp_pkg::alt_mode_t alt_mode;
    logic [`FPP_LINES-1:0] pack;

    //////////////////////////////////////////////////////////////////////
    function automatic logic [DATA_W-1:0] interleave(
        input logic [BW-1:0] ev,
        input logic [BW-1:0] od
    );
        interleave = '0;
        for (int i = 0; i < BW; i++) begin
            interleave[2*i] = ev[i];
            interleave[2*i+1] = od[i];
        end
    endfunction

    function automatic logic [BW-1:0] pick_bits(
        input logic [DATA_W-1:0] w,
        input logic odd
    );
        pick_bits = '0;
        for (int i = 0; i < BW; i++) begin
            pick_bits[i] = w[2*i+int'(odd)];
        end
    endfunction

    function automatic logic [`FPP_LINES-1:0] tft_map(
        input logic [DATA_W-1:0] w
    );
        tft_map = {w[15:12], w[10:7], w[4:1]};
    endfunction

    function automatic logic [31:0] read_mux(
        input logic [`FPP_ADDR_W-1:0] a
    );
        read_mux = '0;
        if (a == `FPP_ADDR_CTRL) begin
            read_mux[`FPP_CTRL_W-1:0] = ctrl_q;
        end else if (a == `FPP_ADDR_STATUS) begin
            read_mux[`FPP_ST_OVF] = ovf_q;
            read_mux[`FPP_ST_EMPTY] = ~fifo_out_valid;
            read_mux[`FPP_ST_FULL] = ~fifo_in_ready;
            read_mux[`FPP_ST_CNT_LO +: CW] = fifo_count;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////
    // register bus slave, zero wait states
    assign addr_ok = hsel & hready & htrans[`FPP_HTRANS_NSEQ];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[`FPP_ADDR_W-1:0];
            end
            hrdata <= (addr_ok && !hwrite) ?
                read_mux(haddr[`FPP_ADDR_W-1:0]) : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= `FPP_CTRL_RST;
        end else if (clk_en) begin
            if (wr_pend_q && wr_addr_q == `FPP_ADDR_CTRL) begin
                ctrl_q <= hwdata[`FPP_CTRL_W-1:0];
            end
        end
    end

    // overflow is sticky; a new overflow beats a write-one clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovf_q <= 1'b0;
        end else if (clk_en) begin
            if (ovf_event) begin
                ovf_q <= 1'b1;
            end else if (wr_pend_q && wr_addr_q == `FPP_ADDR_STATUS &&
                         hwdata[`FPP_ST_OVF]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    assign panel_active = ctrl_q[`FPP_CTRL_OE] & ctrl_q[`FPP_CTRL_PANEL];
    assign stn = ctrl_q[`FPP_CTRL_MODE] == fpp_pkg::MODE_STN;
    assign alt_mode = fpp_pkg::alt_mode_t'(
        ctrl_q[`FPP_CTRL_ALT_HI:`FPP_CTRL_ALT_LO]);

    //////////////////////////////////////////////////////////////////////
    // controller side synchronisers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pd_s1 <= '0;
            pd_s2 <= '0;
            ctl_s1 <= '0;
            ctl_s2 <= '0;
            sck_s3 <= 1'b0;
            lp_s3 <= 1'b0;
        end else if (clk_en) begin
            pd_s1 <= controller_panel_data;
            pd_s2 <= pd_s1;
            ctl_s1 <= {controller_display_active, controller_alt_drive,
                       controller_frame_marker, controller_line_pulse,
                       controller_shift_clock};
            ctl_s2 <= ctl_s1;
            sck_s3 <= ctl_s2[`FPP_SY_SCK];
            lp_s3 <= ctl_s2[`FPP_SY_LP];
        end
    end

    assign cap = ctl_s2[`FPP_SY_SCK] & ~sck_s3;
    assign lp_rise = ctl_s2[`FPP_SY_LP] & ~lp_s3;

    // STN: first byte of a pair holds the even bits, second the odd
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pair_q <= 1'b0;
            even_q <= '0;
        end else if (clk_en) begin
            if (!stn || lp_rise) begin
                pair_q <= 1'b0;
            end else if (cap) begin
                pair_q <= ~pair_q;
            end
            if (cap && !pair_q) begin
                even_q <= pd_s2[BW-1:0];
            end
        end
    end

    assign push_valid = cap & (~stn | (pair_q & ~lp_rise));
    assign push_data = stn ? interleave(even_q, pd_s2[BW-1:0]) : pd_s2;
    assign ovf_event = push_valid & ~fifo_in_ready;

    pixel_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    //////////////////////////////////////////////////////////////////////
    // output clock generator; stalls with the clock low while empty
    assign last = div_q == 8'(HALF_CYCLES - 1);
    assign fifo_out_ready = (st_q == fpp_pkg::OUT_IDLE) |
                            ((st_q == fpp_pkg::OUT_HIGH) & last);
    assign upper_shift_clock = st_q == fpp_pkg::OUT_HIGH;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= fpp_pkg::OUT_IDLE;
            div_q <= '0;
        end else if (clk_en) begin
            unique case (st_q)
                fpp_pkg::OUT_IDLE: begin
                    div_q <= '0;
                    if (fifo_out_valid) begin
                        st_q <= fpp_pkg::OUT_LOW;
                    end
                end
                fpp_pkg::OUT_LOW: begin
                    div_q <= last ? '0 : div_q + 1'b1;
                    if (last) begin
                        st_q <= fpp_pkg::OUT_HIGH;
                    end
                end
                fpp_pkg::OUT_HIGH: begin
                    div_q <= last ? '0 : div_q + 1'b1;
                    if (last) begin
                        st_q <= fifo_out_valid ? fpp_pkg::OUT_LOW :
                                                 fpp_pkg::OUT_IDLE;
                    end
                end
                default: begin
                    st_q <= fpp_pkg::OUT_IDLE;
                    div_q <= '0;
                end
            endcase
        end
    end

    // one word loaded per upper clock period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_q <= '0;
        end else if (clk_en && fifo_out_valid && fifo_out_ready) begin
            word_q <= fifo_out_data;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // panel port drivers
    always_comb begin
        pack = tft_map(word_q);
        if (stn) begin
            pack = '0;
            pack[BW-1:0] = pick_bits(word_q, upper_shift_clock);
            pack[`FPP_LINE_SCK] = upper_shift_clock;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            panel_line <= '0;
            panel_shift_clock <= 1'b0;
            lower_shift_clock <= 1'b0;
        end else if (clk_en) begin
            panel_line <= panel_active ? pack : '0;
            panel_shift_clock <= panel_active & upper_shift_clock;
            lower_shift_clock <= panel_active & stn &
                                 (st_q == fpp_pkg::OUT_LOW);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            line_latch_pulse <= 1'b0;
            first_line_marker <= 1'b0;
            alternating_drive <= 1'b0;
            crt_select <= 1'b1;
            capture_ready <= 1'b0;
        end else if (clk_en) begin
            line_latch_pulse <= panel_active & ctl_s2[`FPP_SY_LP];
            first_line_marker <= panel_active & ctl_s2[`FPP_SY_FLM];
            if (alt_mode == fpp_pkg::ALT_BLANK ||
                alt_mode == fpp_pkg::ALT_DE) begin
                // low while blanking doubles as high while displaying
                alternating_drive <= panel_active &
                                     ctl_s2[`FPP_SY_ACT];
            end else begin
                alternating_drive <= panel_active &
                                     ctl_s2[`FPP_SY_ALT];
            end
            crt_select <= ~ctrl_q[`FPP_CTRL_PANEL];
            capture_ready <= fifo_in_ready;
        end
    end

    //////////////////////////////////////////////////////////////////////
    AST_CRT_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
        crt_select |-> panel_line == '0 && !panel_shift_clock)
        else $error("panel lines active while CRT owns the port");
    AST_OE_GATE: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && !$past(ctrl_q[`FPP_CTRL_OE]) |->
        panel_line == '0 && !line_latch_pulse && !alternating_drive)
        else $error("panel output active without enable");
    AST_TFT_BLUE: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) && !$past(stn) |->
        panel_line[3:0] == $past(word_q[4:1]))
        else $error("blue lines wrong in TFT mode");
    AST_TFT_GREEN: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) && !$past(stn) |->
        panel_line[7:4] == $past(word_q[10:7]))
        else $error("green lines wrong in TFT mode");
    AST_TFT_RED: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) && !$past(stn) |->
        panel_line[11:8] == $past(word_q[15:12]))
        else $error("red lines wrong in TFT mode");
    AST_LOAD_PERIOD: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && fifo_out_valid && fifo_out_ready |=>
        st_q == fpp_pkg::OUT_LOW && div_q == '0)
        else $error("word load not at start of a shift clock period");
    AST_STN_ODD: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) && $past(stn) &&
        $past(upper_shift_clock) |->
        panel_line[7:0] == $past(pick_bits(word_q, 1'b1)) &&
        panel_line[`FPP_LINE_SCK])
        else $error("odd bits not shown while upper clock high");
    AST_STN_EVEN: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) && $past(stn) &&
        !$past(upper_shift_clock) |->
        panel_line[7:0] == $past(pick_bits(word_q, 1'b0)) &&
        !panel_line[`FPP_LINE_SCK])
        else $error("even bits not shown while upper clock low");
    AST_STN_SPARE: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(stn) |-> panel_line[11:9] == '0)
        else $error("spare lines driven in STN mode");
    AST_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) |->
        line_latch_pulse == $past(ctl_s2[`FPP_SY_LP]) &&
        first_line_marker == $past(ctl_s2[`FPP_SY_FLM]))
        else $error("latch pulse or frame marker mismatch");
    AST_ALT: assert property (@(posedge clk) disable iff (sys_rst)
        $past(clk_en) && $past(panel_active) &&
        $past(alt_mode) == fpp_pkg::ALT_DE |->
        alternating_drive == $past(ctl_s2[`FPP_SY_ACT]))
        else $error("display enable not followed");
endmodule

// ### flat_panel_port_packer_bench.sv
// Purpose: self-checking bench of the flat panel port packer
// Assumes: 8 ns system clock, 125 ns controller shift clock
// Notes: slow output stage so the FIFO can be driven full
`timescale 1ns/1ps
`include "fpp_params.svh"
module flat_panel_port_packer_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, crt_select, capture_ready;
    logic [15:0] cdata = 16'h0;
    logic csck = 1'b0, clp = 1'b0, cfm = 1'b0, calt = 1'b0, cact = 1'b0;
    logic [11:0] panel_line;
    logic sck, llp, flm, altd, arm = 1'b0, saw_full = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    logic [15:0] words[4] = '{16'hA5C3, 16'h5A3C, 16'hF00F, 16'h1E96};

    always #4 clk = ~clk;

    flat_panel_port_packer #(.HALF_CYCLES(16)) dut (
        .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .controller_panel_data(cdata),
        .controller_shift_clock(csck), .controller_line_pulse(clp),
        .controller_frame_marker(cfm), .controller_alt_drive(calt),
        .controller_display_active(cact), .panel_line(panel_line),
        .panel_shift_clock(sck), .lower_shift_clock(),
        .line_latch_pulse(llp), .first_line_marker(flm),
        .alternating_drive(altd), .crt_select(crt_select),
        .capture_ready(capture_ready));

    panel_model pm (.clk(clk), .panel_line(panel_line),
        .panel_shift_clock(sck));

    always @(posedge clk) begin
        if (arm && capture_ready === 1'b0) begin
            saw_full <= 1'b1;
        end
    end

    function automatic logic [11:0] tft(input logic [15:0] w);
        return {w[15:12], w[10:7], w[4:1]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one AHB-Lite single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1 && ++n < 50);
        rd = hrdata;
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    // one controller word; data released to its inverse after the clock
    task automatic send(input logic [15:0] w);
        cdata <= w;
        #30;
        csck <= 1'b1;
        #62.5;
        csck <= 1'b0;
        cdata <= ~w;
        #32.5;
    endtask

    task automatic wait_caps(input int n);
        int k;
        k = 0;
        while (pm.captured.size() < n && k < 3000) begin
            @(posedge clk);
            k++;
        end
        check(32'(pm.captured.size()), 32'(n));
    endtask

    initial begin
        #400000;
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check({hreadyout, crt_select, panel_line}, 32'h3000);
        bus(1'b0, `FPP_ADDR_CTRL, 32'h0);
        check(rd, 32'h0);
        bus(1'b0, `FPP_ADDR_STATUS, 32'h0);
        check(rd, 32'h2);
        bus(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0);
        clp <= 1'b1;
        cfm <= 1'b1;
        calt <= 1'b1;
        cact <= 1'b1;
        // CRT, enable without panel, panel without enable
        for (int c = 0; c < 3; c++) begin
            bus(1'b1, `FPP_ADDR_CTRL, 32'(c));
            settle();
            check({sck, llp, flm, altd, panel_line}, 32'h0);
            check(crt_select, c != 2);
        end
        bus(1'b1, `FPP_ADDR_CTRL, 32'h3);
        settle();
        check({llp, flm}, 32'h3);
        clp <= 1'b0;
        settle();
        check({llp, flm}, 32'h1);
        cfm <= 1'b0;
        cact <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, `FPP_ADDR_CTRL, 32'(m * 8 + 3));
            bus(1'b0, `FPP_ADDR_CTRL, 32'h0);
            check(rd, 32'(m * 8 + 3));
            settle();
            check(altd, m == 0 || m == 3);
        end
        bus(1'b1, `FPP_ADDR_CTRL, 32'h0B);
        calt <= 1'b0;
        cact <= 1'b1;
        settle();
        check(altd, 1'b1);
        bus(1'b1, `FPP_ADDR_CTRL, 32'h3);
        pm.captured.delete();
        foreach (words[i]) send(words[i]);
        wait_caps(8);
        foreach (words[i]) begin
            check(pm.captured[2 * i], tft(words[i]));
            check(pm.captured[2 * i + 1], tft(words[i]));
        end
        check(sck, 1'b0);
        bus(1'b1, `FPP_ADDR_CTRL, 32'h7);
        clp <= 1'b1;
        settle();
        clp <= 1'b0;
        settle();
        pm.captured.delete();
        foreach (words[i]) send(words[i]);
        wait_caps(4);
        for (int i = 0; i < 2; i++) begin
            check(pm.captured[2 * i], {4'h0, words[2 * i][7:0]});
            check(pm.captured[2 * i + 1], {4'h1, words[2 * i + 1][7:0]});
        end
        bus(1'b1, `FPP_ADDR_CTRL, 32'h3);
        arm <= 1'b1;
        repeat (20) send(16'h0F0F);
        bus(1'b0, `FPP_ADDR_STATUS, 32'h0);
        check(rd[0], 1'b1);
        check(saw_full, 1'b1);
        bus(1'b1, `FPP_ADDR_STATUS, 32'h1);
        for (int k = 0; k < 200 && rd[1] !== 1'b1; k++) begin
            bus(1'b0, `FPP_ADDR_STATUS, 32'h0);
        end
        check(rd, 32'h2);
        complete_run();
    end
endmodule

// ### fpp_params.svh
// Purpose: constants of the flat panel port packer
// Assumes: 125 MHz system clock
// Notes: offsets are byte addresses on the register bus
`ifndef FPP_PARAMS_SVH
`define FPP_PARAMS_SVH
`define FPP_CLK_PERIOD_NS 8
`define FPP_HALF_PERIOD_NS 56
`define FPP_HALF_CYCLES ((`FPP_HALF_PERIOD_NS) / (`FPP_CLK_PERIOD_NS))
`define FPP_DATA_W 16
`define FPP_BYTE_W 8
`define FPP_FIFO_DEPTH 8
`define FPP_LINES 12
`define FPP_ADDR_W 8
`define FPP_ADDR_CTRL 8'h00
`define FPP_ADDR_STATUS 8'h04
`define FPP_CTRL_W 5
`define FPP_CTRL_RST 5'h00
`define FPP_CTRL_OE 0
`define FPP_CTRL_PANEL 1
`define FPP_CTRL_MODE 2
`define FPP_CTRL_ALT_LO 3
`define FPP_CTRL_ALT_HI 4
`define FPP_ST_OVF 0
`define FPP_ST_EMPTY 1
`define FPP_ST_FULL 2
`define FPP_ST_CNT_LO 3
`define FPP_SY_SCK 0
`define FPP_SY_LP 1
`define FPP_SY_FLM 2
`define FPP_SY_ALT 3
`define FPP_SY_ACT 4
`define FPP_SY_W 5
`define FPP_LINE_SCK 8
`define FPP_HTRANS_NSEQ 1
`endif

// ### fpp_pkg.sv
// Purpose: types shared by the flat panel port packer
// Assumes: nothing
// Notes: constants live in fpp_params.svh
package fpp_pkg;
    typedef enum logic {MODE_TFT, MODE_STN} panel_mode_t;
    typedef enum logic [1:0] {ALT_M, ALT_BLANK, ALT_DE, ALT_SPARE} alt_mode_t;
    typedef enum logic [1:0] {OUT_IDLE, OUT_LOW, OUT_HIGH} out_state_t;
endpackage

// ### panel_model.sv
// Purpose: flat panel receiver that records the panel lines
// Assumes: shift clock idles low; sampled on the system clock
// Notes: one entry per half period, low half first
`timescale 1ns/1ps
`include "fpp_params.svh"
module panel_model (
    input wire logic clk,
    input wire logic [`FPP_LINES-1:0] panel_line,
    input wire logic panel_shift_clock
);
    logic [`FPP_LINES-1:0] captured[$];
    logic [`FPP_LINES-1:0] line_prev = '0;
    logic sck_prev = 1'b0;
    // lines seen just before each shift clock edge belong to the half
    always @(posedge clk) begin
        if (panel_shift_clock !== sck_prev && sck_prev !== 1'bx) begin
            captured.push_back(line_prev);
        end
        sck_prev <= panel_shift_clock;
        line_prev <= panel_line;
    end
endmodule

// ### pixel_fifo.sv
// Purpose: word FIFO between capture and panel output
// Assumes: one clock, synchronous active-high reset
// Notes: in_ready is low exactly while full
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = cnt_q != DEPTH[$clog2(DEPTH+1)-1:0];
    assign out_valid = cnt_q != '0;
    assign out_data = mem[rd_ptr_q];
    assign count = cnt_q;
    assign push = in_valid & in_ready & clk_en;
    assign pop = out_valid & out_ready & clk_en;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= bump(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= bump(rd_ptr_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
